// ---- src/scan_dff_regs.svh ----
// reset values of the scan flip-flop with asynchronous set and clear
`ifndef SCAN_DFF_REGS_SVH
`define SCAN_DFF_REGS_SVH

`define TRUE_OUT_RESET 1'h0
`define INVERTED_OUT_RESET 1'h1
`define EDGE_SAMPLE_RESET 1'h0
`define UNUSED_OUT_VALUE 1'h0

`endif

// ---- src/scan_dff_pkg.sv ----
// types shared by the scan flip-flop files
package scan_dff_pkg;

  // gray along hold -> data -> scan
  typedef enum logic [1:0] {
    src_hold = 2'h0,
    src_data = 2'h1,
    src_scan = 2'h3
  } load_src_t;

endpackage

// ---- src/forced_bit_cell.sv ----
// one storage bit with active-low force-high and force-low inputs
`timescale 1ns/100ps
`default_nettype none

module forced_bit_cell #(
  parameter bit reset_value = 1'h0
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // asynchronous forces, force-low wins when both are low
  input wire logic force_hi_n,
  input wire logic force_lo_n,
  // capture
  input wire logic load,
  input wire logic d,
  // stored bit
  output logic q
);

  // forces act without the clock and ignore clk_en on purpose
  always_ff @(posedge ref_clk or negedge rstn or negedge force_lo_n
              or negedge force_hi_n) begin
    if (!rstn) begin
      q <= reset_value;
    end else if (!force_lo_n) begin
      q <= 1'h0;
    end else if (!force_hi_n) begin
      q <= 1'h1;
    end else if (clk_en && load) begin
      q <= d;
    end
  end

endmodule // forced_bit_cell

`default_nettype wire

// ---- src/scan_dff_set_reset.sv ----
// scan flip-flop with asynchronous set and clear, true and inverted outputs
`timescale 1ns/100ps
`default_nettype none
`include "scan_dff_regs.svh"

module scan_dff_set_reset #(
  parameter bit has_scan = 1'h1,
  parameter bit has_inverted = 1'h1
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // capture inputs
  input wire logic edge_clock,
  input wire logic data_in,
  input wire logic scan_in,
  input wire logic scan_select,
  // asynchronous forces
  input wire logic async_set_n,
  input wire logic async_clear_n,
  // outputs
  output logic true_out,
  output logic inverted_out
);

  function automatic scan_dff_pkg::load_src_t pick_source(
    input logic rise,
    input logic use_scan
  );
    if (!rise) begin
      pick_source = scan_dff_pkg::src_hold;
    end else if (use_scan) begin
      pick_source = scan_dff_pkg::src_scan;
    end else begin
      pick_source = scan_dff_pkg::src_data;
    end
  endfunction

  logic edge_clock_q;
  wire logic edge_rise;
  wire logic scan_active;
  wire logic do_load;
  wire logic next_true;
  scan_dff_pkg::load_src_t load_src;

  // edge_clock is a sampled level; a rise needs one low sample first
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      edge_clock_q <= `EDGE_SAMPLE_RESET;
    end else if (clk_en) begin
      edge_clock_q <= edge_clock;
    end
  end

  assign edge_rise = edge_clock & ~edge_clock_q;
  assign scan_active = has_scan & scan_select;
  assign load_src = pick_source(edge_rise, scan_active);
  assign do_load = (load_src != scan_dff_pkg::src_hold);
  assign next_true = (load_src == scan_dff_pkg::src_scan) ? scan_in
                                                          : data_in;

  // limitation: a force still low when reset or the other force lets go
  // shows only at the next ref_clk edge, as no edge wakes the cell then
  // clear beats set on the true bit
  forced_bit_cell #(
    .reset_value(`TRUE_OUT_RESET)
  ) true_cell (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .force_hi_n(async_set_n),
    .force_lo_n(async_clear_n),
    .load(do_load),
    .d(next_true),
    .q(true_out)
  );

  generate
    if (has_inverted) begin : g_inv
      // set beats clear here, so both low gives zero on each output
      forced_bit_cell #(
        .reset_value(`INVERTED_OUT_RESET)
      ) inv_cell (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .force_hi_n(async_clear_n),
        .force_lo_n(async_set_n),
        .load(do_load),
        .d(~next_true),
        .q(inverted_out)
      );
    end else begin : g_no_inv
      // the port stays for a uniform header but is held low
      forced_bit_cell #(
        .reset_value(`UNUSED_OUT_VALUE)
      ) inv_cell (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .force_hi_n(1'h1),
        .force_lo_n(1'h1),
        .load(1'h0),
        .d(1'h0),
        .q(inverted_out)
      );
    end
  endgenerate

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  wire logic forces_idle = async_set_n & async_clear_n;

  property p_capture_data;
    (forces_idle && clk_en && edge_rise && !scan_active)
      |=> (!forces_idle || true_out == $past(data_in));
  endproperty
  a_capture_data: assert property (p_capture_data)
    else $error("data input not captured on rising edge");

  property p_capture_scan;
    (has_scan && forces_idle && clk_en && edge_rise && scan_select)
      |=> (!forces_idle || true_out == $past(scan_in));
  endproperty
  a_capture_scan: assert property (p_capture_scan)
    else $error("scan input not captured with scan select high");

  property p_set_forces;
    (!async_set_n && async_clear_n && $past(async_clear_n))
      |-> (true_out && (!has_inverted || !inverted_out));
  endproperty
  a_set_forces: assert property (p_set_forces)
    else $error("set did not force outputs");

  property p_clear_forces;
    !async_clear_n
      |-> (!true_out && (!has_inverted || inverted_out == async_set_n
                         || (async_set_n && !$past(async_set_n))));
  endproperty
  a_clear_forces: assert property (p_clear_forces)
    else $error("clear did not force outputs");

  property p_hold;
    (forces_idle && (!clk_en || !edge_rise)) ##1 forces_idle
      |-> $stable(true_out) && $stable(inverted_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("outputs changed without edge or force");

  property p_true_only;
    !has_inverted |-> !inverted_out;
  endproperty
  a_true_only: assert property (p_true_only)
    else $error("inverted output driven in true-only variant");

  property p_complement;
    (has_inverted && (async_set_n || async_clear_n)
     && $past(async_set_n || async_clear_n))
      |-> (inverted_out == !true_out);
  endproperty
  a_complement: assert property (p_complement)
    else $error("inverted output is not the complement");

  property p_release_true;
    (!async_set_n && !async_clear_n) ##1 (!async_set_n && async_clear_n)
      |=> (!async_clear_n || true_out);
  endproperty
  a_release_true: assert property (p_release_true)
    else $error("true output not set one edge after clear release");

  property p_release_inv;
    (!async_set_n && !async_clear_n) ##1 (async_set_n && !async_clear_n)
      |=> (!has_inverted || !async_set_n || inverted_out);
  endproperty
  a_release_inv: assert property (p_release_inv)
    else $error("inverted output not set one edge after set release");

  property p_both_low;
    (!async_set_n && !async_clear_n) |-> (!true_out && !inverted_out);
  endproperty
  a_both_low: assert property (p_both_low)
    else $error("both forces low but an output is high");

  property p_edge_sample;
    clk_en |=> (edge_clock_q == $past(edge_clock));
  endproperty
  a_edge_sample: assert property (p_edge_sample)
    else $error("edge sampler missed the capture strobe");

  property p_freeze;
    !clk_en |=> $stable(edge_clock_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("edge sampler moved with the enable low");

  property p_scan_ignored;
    (!has_scan && forces_idle && clk_en && edge_rise && scan_select)
      |=> (!forces_idle || true_out == $past(data_in));
  endproperty
  a_scan_ignored: assert property (p_scan_ignored)
    else $error("scan input taken in the variant without scan");

  c_scan_load: cover property (forces_idle && clk_en && edge_rise
                               && scan_active);
  c_data_load: cover property (forces_idle && clk_en && edge_rise
                               && !scan_active ##1 true_out);
  c_set_then_clear: cover property (!async_set_n ##[1:4] !async_clear_n);
  c_both_low: cover property (!async_set_n && !async_clear_n);
  c_release_from_both: cover property ((!async_set_n && !async_clear_n)
                                       ##1 (async_set_n && !async_clear_n));

endmodule // scan_dff_set_reset

`default_nettype wire

// ---- bench/tb_scan_dff_set_reset.sv ----
// self-checking bench of the scan flip-flop with set and clear
`timescale 1ns/100ps
`default_nettype none

module tb_scan_dff_set_reset;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic clk_en = 1'h0;
  logic edge_clock = 1'h0;
  logic data_in = 1'h0;
  logic scan_in = 1'h0;
  logic scan_select = 1'h0;
  logic async_set_n = 1'h1;
  logic async_clear_n = 1'h1;
  logic true_out, inverted_out, only_out, only_inv;
  logic plain_out, plain_inv;
  logic q_reg = 1'h0;
  logic ns_reg = 1'h0;
  logic prev_edge = 1'h0;
  logic dir = 1'h0;
  int error_cnt = 0;
  int tests_run = 0;
  int r;

  always #2 ref_clk = ~ref_clk;

  scan_dff_set_reset DUT (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
    .edge_clock(edge_clock), .data_in(data_in), .scan_in(scan_in),
    .scan_select(scan_select), .async_set_n(async_set_n),
    .async_clear_n(async_clear_n), .true_out(true_out),
    .inverted_out(inverted_out));
  scan_dff_set_reset #(.has_inverted(1'h0)) DUT_q (.ref_clk(ref_clk),
    .rstn(rstn), .clk_en(clk_en), .edge_clock(edge_clock),
    .data_in(data_in), .scan_in(scan_in), .scan_select(scan_select),
    .async_set_n(async_set_n), .async_clear_n(async_clear_n),
    .true_out(only_out), .inverted_out(only_inv));
  scan_dff_set_reset #(.has_scan(1'h0)) DUT_ns (.ref_clk(ref_clk),
    .rstn(rstn), .clk_en(clk_en), .edge_clock(edge_clock),
    .data_in(data_in), .scan_in(scan_in), .scan_select(scan_select),
    .async_set_n(async_set_n), .async_clear_n(async_clear_n),
    .true_out(plain_out), .inverted_out(plain_inv));

  task automatic check(input string name, input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // clear wins, then set, else the held bit
  function automatic logic forced_level(input logic s, input logic c,
                                        input logic held);
    forced_level = !c ? 1'h0 : (!s ? 1'h1 : held);
  endfunction

  // reference: forces win over capture, capture only on a sampled rise
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q_reg = 1'h0;
      ns_reg = 1'h0;
      prev_edge = 1'h0;
    end else begin
      if (clk_en && edge_clock && !prev_edge) begin
        q_reg = scan_select ? scan_in : data_in;
        ns_reg = data_in;
      end
      q_reg = forced_level(async_set_n, async_clear_n, q_reg);
      ns_reg = forced_level(async_set_n, async_clear_n, ns_reg);
      if (clk_en) prev_edge = edge_clock;
    end
  end

  always @(negedge ref_clk) begin : cmp
    logic eq;
    logic eq_plain;
    eq = forced_level(async_set_n, async_clear_n, q_reg);
    eq_plain = forced_level(async_set_n, async_clear_n, ns_reg);
    if (!rstn) begin
      check("reset true_out", true_out, 1'h0);
      check("reset inverted_out", inverted_out, 1'h1);
    end else if (!dir) begin
      check("true_out", true_out, eq);
      check("inverted_out", inverted_out, ~eq);
      check("only true_out", only_out, eq);
      check("only inverted_out", only_inv, 1'h0);
      check("plain true_out", plain_out, eq_plain);
      check("plain inverted_out", plain_inv, ~eq_plain);
    end
  end

  // x as an expected value, true or inverted, skips that check: the cell settles on the next edge
  task automatic force_step(input logic s, input logic c, input logic eq,
                            input logic eqn);
    @(posedge ref_clk);
    async_set_n <= s;
    async_clear_n <= c;
    @(negedge ref_clk);
    if (eq !== 1'hx) check("forced true_out", true_out, eq);
    if (eqn !== 1'hx) check("forced inverted_out", inverted_out, eqn);
  endtask

  initial begin
    r = $urandom(93);
    repeat (12) @(posedge ref_clk);
    rstn <= 1'h1;
    repeat (1500) begin
      @(posedge ref_clk);
      r = $urandom % 8;
      clk_en <= 1'($urandom % 4 != 0);
      edge_clock <= 1'($urandom);
      data_in <= 1'($urandom);
      scan_in <= 1'($urandom);
      scan_select <= 1'($urandom);
      // one force at a time, from idle, never at a reset release
      if (async_set_n && async_clear_n && rstn) begin
        async_set_n <= 1'(r != 0);
        async_clear_n <= 1'(r != 1);
      end else begin
        async_set_n <= 1'h1;
        async_clear_n <= 1'h1;
      end
      rstn <= 1'(r != 7);
    end
    @(posedge ref_clk);
    edge_clock <= 1'h0;
    dir <= 1'h1;
    rstn <= 1'h1;
    clk_en <= 1'h1;
    async_set_n <= 1'h1;
    async_clear_n <= 1'h1;
    force_step(1'h1, 1'h0, 1'h0, 1'h1);
    force_step(1'h0, 1'h0, 1'h0, 1'h0);
    force_step(1'h1, 1'h0, 1'h0, 1'hx);
    force_step(1'h1, 1'h0, 1'h0, 1'h1);
    force_step(1'h1, 1'h1, 1'h0, 1'h1);
    force_step(1'h0, 1'h1, 1'h1, 1'h0);
    force_step(1'h1, 1'h1, 1'h1, 1'h0);
    force_step(1'h0, 1'h0, 1'h0, 1'h0);
    force_step(1'h0, 1'h1, 1'hx, 1'h0);
    force_step(1'h0, 1'h1, 1'h1, 1'h0);
    force_step(1'h1, 1'h1, 1'h1, 1'h0);
    summarize();
  end

  initial begin
    #40000;
    error_cnt++;
    summarize();
  end
endmodule // tb_scan_dff_set_reset

`default_nettype wire
